/* File: regulator_pkg.sv */
// Purpose: Shared constants and types for the regulator control registers
// Assumes: 8-bit registers, 6-bit voltage codes, millivolt arithmetic
// Notes:   Defaults differ per device variant
package regulator_pkg;

    localparam logic [7:0] BUCK_SETTING_ADDR        = 8'h07;
    localparam logic [7:0] LINREG_SETTING_ADDR      = 8'h08;
    localparam logic [7:0] MODE_AND_POWER_GOOD_ADDR = 8'h09;

    localparam int HOLD_KEEP_BIT      = 7;
    localparam int DISCHARGE_BIT      = 6;
    localparam int FORCED_PWM_BIT     = 7;
    localparam int BUCK_POWER_BAD_BIT = 6;
    localparam int LINREG_BAD_BIT     = 5;

    // Variant selection, one-hot
    typedef enum logic [3:0] {
        VARIANT_BASE    = 4'h1,
        VARIANT_MEASURE = 4'h2,
        VARIANT_ALT_OUT = 4'h4,
        VARIANT_LARGE   = 4'h8
    } variant_e;

    localparam logic [7:0] BUCK_DEFAULT_BASE    = 8'h29;
    localparam logic [7:0] BUCK_DEFAULT_MEASURE = 8'h25;
    localparam logic [7:0] BUCK_DEFAULT_ALT_OUT = 8'h26;
    localparam logic [7:0] LINREG_DEFAULT       = 8'h65;
    localparam logic [7:0] LINREG_DEFAULT_ALT   = 8'h79;
    localparam logic       FORCED_PWM_DEFAULT   = 1'b0;

    // Code to millivolt table segments
    localparam logic [11:0] FINE_BASE_MV    = 12'd800;
    localparam logic [11:0] FINE_STEP_MV    = 12'd25;
    localparam logic [11:0] COARSE_BASE_MV  = 12'd1600;
    localparam logic [11:0] COARSE_STEP_MV  = 12'd50;
    localparam logic [11:0] TOP_BASE_MV     = 12'd3100;
    localparam logic [11:0] TOP_STEP_MV     = 12'd100;
    localparam logic [5:0]  COARSE_FIRST    = 6'd32;
    localparam logic [5:0]  TOP_FIRST       = 6'd61;
    localparam logic [11:0] MAX_MV          = 12'd3300;

    // Upward step limit in percent
    localparam logic [6:0]  STEP_LIMIT_PCT  = 7'd8;
    localparam logic [6:0]  PCT_SCALE       = 7'd100;

    typedef struct packed {
        logic       hold_keep;
        logic       discharge;
        logic [5:0] code;
    } setting_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       write;
        logic       read;
    } reg_req_s;

    typedef struct packed {
        logic       hold;
        logic       pushbutton_n;
        logic       in_range;
    } rail_pins_s;

endpackage

/* File: pin_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter per bit
// Assumes: Inputs asynchronous to mclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    input  wire logic             mclk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1;
            logic s2;
            logic s3;
            logic next_level;
            always_comb begin
                next_level = (s2 == s3) ? s3 : level[i];
            end
            always_ff @(posedge mclk) begin
                if (!resetn) begin
                    s1       <= RESET_VAL[i];
                    s2       <= RESET_VAL[i];
                    s3       <= RESET_VAL[i];
                    level[i] <= RESET_VAL[i];
                end else begin
                    s1       <= pin[i];
                    s2       <= s1;
                    s3       <= s2;
                    level[i] <= next_level;
                end
            end
        end
    endgenerate
endmodule

/* File: voltage_decode.sv */
// Purpose: Maps a 6-bit voltage code to millivolts
// Assumes: Three linear segments of the code table
// Notes:   Purely combinational
`timescale 1ns/1ps
module voltage_decode (
    input  wire logic [5:0]  code,
    output logic      [11:0] millivolts
);
    import regulator_pkg::*;

    logic [5:0] offset;

    always_comb begin
        offset     = 6'h00;
        millivolts = FINE_BASE_MV;
        if (code < COARSE_FIRST) begin
            offset     = code;
            millivolts = 12'(FINE_BASE_MV + FINE_STEP_MV * 12'(offset));
        end else if (code < TOP_FIRST) begin
            offset     = 6'(code - COARSE_FIRST);
            millivolts = 12'(COARSE_BASE_MV + COARSE_STEP_MV * 12'(offset));
        end else begin
            offset     = 6'(code - TOP_FIRST);
            millivolts = 12'(TOP_BASE_MV + TOP_STEP_MV * 12'(offset));
        end
    end
endmodule

/* File: regulator_control_regs.sv */
// Purpose: Control and status registers for buck converter and linear reg
// Assumes: Register access strobes come from a serial slave on mclk
// Notes:   Defaults chosen by VARIANT; pins pass three-stage sync
`timescale 1ns/1ps
module regulator_control_regs #(
    parameter regulator_pkg::variant_e VARIANT = regulator_pkg::VARIANT_BASE
) (
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire regulator_pkg::reg_req_s req,
    output logic [7:0]                   rdata,
    output logic                         rvalid,
    input  wire regulator_pkg::rail_pins_s buck_pins,
    input  wire regulator_pkg::rail_pins_s linreg_pins,
    input  wire logic                    undervoltage_or_reset_load,
    output logic                         buck_enable,
    output logic                         linreg_enable,
    output logic                         buck_out_discharge,
    output logic                         linreg_out_discharge,
    output logic [5:0]                   buck_applied_code,
    output logic [5:0]                   linreg_applied_code,
    output logic [11:0]                  buck_target_mv,
    output logic [11:0]                  linreg_target_mv,
    output logic                         forced_pwm,
    output logic                         overstep_reset
);
    import regulator_pkg::*;

    // Variant-dependent defaults and behaviour
    localparam logic BUCK_FIXED =
        (VARIANT == VARIANT_MEASURE) || (VARIANT == VARIANT_ALT_OUT);
    localparam logic LINREG_FIXED = (VARIANT != VARIANT_LARGE);
    localparam logic [7:0] BUCK_DEFAULT =
        (VARIANT == VARIANT_MEASURE) ? BUCK_DEFAULT_MEASURE :
        (VARIANT == VARIANT_ALT_OUT) ? BUCK_DEFAULT_ALT_OUT :
                                       BUCK_DEFAULT_BASE;
    localparam logic [7:0] LINREG_DEFAULT_V =
        (VARIANT == VARIANT_ALT_OUT) ? LINREG_DEFAULT_ALT : LINREG_DEFAULT;

    setting_s   buck_setting;
    setting_s   linreg_setting;
    logic       forced_pwm_sel;
    setting_s   next_buck_setting;
    setting_s   next_linreg_setting;
    logic       next_forced_pwm_sel;

    logic [5:0] sync_in;
    logic [5:0] sync_out;
    logic       hold_buck_s;
    logic       hold_linreg_s;
    logic       pb_released_s;
    logic       buck_in_range_s;
    logic       linreg_in_range_s;
    logic       uvlo_s;

    logic [11:0] buck_cur_mv;
    logic [11:0] buck_new_mv;
    logic [18:0] new_scaled;
    logic [18:0] limit_scaled;
    logic        buck_write;
    logic        step_too_big;

    logic       next_buck_enable;
    logic       next_linreg_enable;
    logic       next_buck_disch;
    logic       next_linreg_disch;
    logic [5:0] next_buck_applied;
    logic [5:0] next_linreg_applied;
    logic       next_overstep;
    logic [7:0] next_rdata;
    logic       next_rvalid;

    // Pin synchronisers
    assign sync_in = {undervoltage_or_reset_load, linreg_pins.in_range,
                      buck_pins.in_range, buck_pins.pushbutton_n,
                      linreg_pins.hold, buck_pins.hold};

    pin_sync #(
        .WIDTH     (6),
        .RESET_VAL (8'h04)
    ) u_pin_sync (
        .mclk   (mclk),
        .resetn (resetn),
        .pin    (sync_in),
        .level  (sync_out)
    );

    assign hold_buck_s       = sync_out[0];
    assign hold_linreg_s     = sync_out[1];
    assign pb_released_s     = sync_out[2];
    assign buck_in_range_s   = sync_out[3];
    assign linreg_in_range_s = sync_out[4];
    assign uvlo_s            = sync_out[5];

    // Voltage decoders
    voltage_decode u_buck_cur (
        .code       (buck_setting.code),
        .millivolts (buck_cur_mv)
    );

    voltage_decode u_buck_new (
        .code       (req.wdata[5:0]),
        .millivolts (buck_new_mv)
    );

    voltage_decode u_buck_applied (
        .code       (buck_applied_code),
        .millivolts (buck_target_mv)
    );

    voltage_decode u_linreg_applied (
        .code       (linreg_applied_code),
        .millivolts (linreg_target_mv)
    );

    // Register writes
    always_comb begin
        next_buck_setting   = buck_setting;
        next_linreg_setting = linreg_setting;
        next_forced_pwm_sel = forced_pwm_sel;
        if (uvlo_s) begin
            next_buck_setting   = BUCK_DEFAULT;
            next_linreg_setting = LINREG_DEFAULT_V;
            next_forced_pwm_sel = FORCED_PWM_DEFAULT;
        end else if (req.write) begin
            unique case (req.addr)
                BUCK_SETTING_ADDR:   next_buck_setting   = req.wdata;
                LINREG_SETTING_ADDR: next_linreg_setting = req.wdata;
                MODE_AND_POWER_GOOD_ADDR:
                    next_forced_pwm_sel =
                        req.wdata[FORCED_PWM_BIT];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            buck_setting   <= BUCK_DEFAULT;
            linreg_setting <= LINREG_DEFAULT_V;
            forced_pwm_sel <= FORCED_PWM_DEFAULT;
        end else begin
            buck_setting   <= next_buck_setting;
            linreg_setting <= next_linreg_setting;
            forced_pwm_sel <= next_forced_pwm_sel;
        end
    end

    // Upward step check against the present setting
    assign buck_write   = req.write && !uvlo_s
                          && (req.addr == BUCK_SETTING_ADDR);
    assign new_scaled   = 19'(buck_new_mv) * 19'(PCT_SCALE);
    assign limit_scaled = 19'(buck_cur_mv) * 19'(PCT_SCALE + STEP_LIMIT_PCT);
    assign step_too_big = new_scaled > limit_scaled;

    // Rail control and status
    always_comb begin
        next_buck_enable   = hold_buck_s || !pb_released_s
                             || (buck_enable && buck_setting.hold_keep);
        next_linreg_enable = hold_linreg_s || !pb_released_s
                             || (linreg_enable && linreg_setting.hold_keep);
        next_buck_disch    = buck_setting.discharge && !buck_enable;
        next_linreg_disch  = linreg_setting.discharge && !linreg_enable;
        next_buck_applied  = BUCK_FIXED ? buck_setting.code
                                        : BUCK_DEFAULT[5:0];
        next_linreg_applied = LINREG_FIXED ? linreg_setting.code
                                           : LINREG_DEFAULT_V[5:0];
        next_overstep      = buck_write && BUCK_FIXED && buck_enable
                             && step_too_big;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            buck_enable          <= 1'b0;
            linreg_enable        <= 1'b0;
            buck_out_discharge   <= 1'b0;
            linreg_out_discharge <= 1'b0;
            buck_applied_code    <= BUCK_DEFAULT[5:0];
            linreg_applied_code  <= LINREG_DEFAULT_V[5:0];
            forced_pwm           <= FORCED_PWM_DEFAULT;
            overstep_reset       <= 1'b0;
        end else begin
            buck_enable          <= next_buck_enable;
            linreg_enable        <= next_linreg_enable;
            buck_out_discharge   <= next_buck_disch;
            linreg_out_discharge <= next_linreg_disch;
            buck_applied_code    <= next_buck_applied;
            linreg_applied_code  <= next_linreg_applied;
            forced_pwm           <= forced_pwm_sel;
            overstep_reset       <= next_overstep;
        end
    end

    // Read path
    always_comb begin
        next_rdata  = 8'h00;
        next_rvalid = req.read;
        if (req.read) begin
            unique case (req.addr)
                BUCK_SETTING_ADDR:   next_rdata = buck_setting;
                LINREG_SETTING_ADDR: next_rdata = linreg_setting;
                MODE_AND_POWER_GOOD_ADDR: begin
                    next_rdata[FORCED_PWM_BIT] = forced_pwm_sel;
                    next_rdata[BUCK_POWER_BAD_BIT] =
                        !buck_enable || !buck_in_range_s;
                    next_rdata[LINREG_BAD_BIT] =
                        !linreg_enable || !linreg_in_range_s;
                end
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
        end
    end

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    buck_turns_off_a: assert property (
        (!buck_setting.hold_keep && !hold_buck_s && pb_released_s)
        |=> !buck_enable)
        else $error("buck stayed on without hold");

    buck_discharge_a: assert property (
        (buck_setting.discharge && !buck_enable) |=> buck_out_discharge)
        else $error("buck output not discharged");

    code_table_a: assert property (
        (buck_applied_code == 6'h3f) |-> (buck_target_mv == MAX_MV))
        else $error("top code does not give top voltage");

    buck_divider_a: assert property (
        !BUCK_FIXED |-> (buck_applied_code == BUCK_DEFAULT[5:0]))
        else $error("buck code applied on divider variant");

    overstep_trip_a: assert property (
        (buck_write && BUCK_FIXED && buck_enable && step_too_big)
        |=> overstep_reset ##1 !overstep_reset)
        else $error("large step did not trip once");

    linreg_turns_off_a: assert property (
        (!linreg_setting.hold_keep && !hold_linreg_s && pb_released_s)
        |=> !linreg_enable)
        else $error("regulator stayed on without hold");

    linreg_discharge_a: assert property (
        (linreg_out_discharge) |-> $past(linreg_setting.discharge)
        && !$past(linreg_enable))
        else $error("regulator discharged wrongly");

    linreg_divider_a: assert property (
        !LINREG_FIXED |-> (linreg_applied_code == LINREG_DEFAULT_V[5:0]))
        else $error("regulator code applied on divider variant");

    pwm_select_a: assert property (
        (req.write && !uvlo_s && req.addr == MODE_AND_POWER_GOOD_ADDR)
        |=> ##1 (forced_pwm == $past(req.wdata[FORCED_PWM_BIT], 2)))
        else $error("forced pwm not taken");

    buck_bad_read_a: assert property (
        (req.read && req.addr == MODE_AND_POWER_GOOD_ADDR && !buck_enable)
        |=> rdata[BUCK_POWER_BAD_BIT])
        else $error("buck power bad not shown");

    linreg_bad_read_a: assert property (
        (req.read && req.addr == MODE_AND_POWER_GOOD_ADDR
         && linreg_enable && linreg_in_range_s)
        |=> !rdata[LINREG_BAD_BIT])
        else $error("regulator power bad wrong");

    defaults_reload_a: assert property (
        uvlo_s |=> (buck_setting == BUCK_DEFAULT)
        && (linreg_setting == LINREG_DEFAULT_V) && !forced_pwm_sel)
        else $error("defaults not reloaded");

    low_bits_zero_a: assert property (
        (req.read && req.addr == MODE_AND_POWER_GOOD_ADDR)
        |=> (rdata[4:0] == 5'h00) && rvalid)
        else $error("reserved bits not zero");

endmodule

/* File: regulator_host_model.sv */
// Purpose: Host side of the register port, issues single reads and writes
// Assumes: Strobes change at the falling edge of mclk
// Notes:   Released address and data lines show the inverse of the last use
`timescale 1ns/1ps
module regulator_host_model (
    input  wire logic               mclk,
    output regulator_pkg::reg_req_s req,
    input  wire logic [7:0]         rdata,
    input  wire logic               rvalid
);
    import regulator_pkg::*;

    initial req = '0;

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] dat);
        @(negedge mclk);
        req <= '{addr: a, wdata: dat, write: 1'b1, read: 1'b0};
        @(negedge mclk);
        req <= '{addr: ~a, wdata: ~dat, write: 1'b0, read: 1'b0};
    endtask

    // One-cycle read strobe, data taken while rvalid stands
    task automatic rd(input logic [7:0] a, output logic [7:0] dat,
                      output logic vld);
        @(negedge mclk);
        req <= '{addr: a, wdata: 8'h5a, write: 1'b0, read: 1'b1};
        @(negedge mclk);
        req <= '{addr: ~a, wdata: 8'ha5, write: 1'b0, read: 1'b0};
        dat = rdata;
        vld = rvalid;
    endtask
endmodule

/* File: tb_regulator_control_regs.sv */
// Purpose: Self-checking bench for the regulator control registers
// Assumes: Fixed-output variant checked fully, divider variant beside it
// Notes:   Random settings plus table corners, rails, overstep and reload
`timescale 1ns/1ps
module tb_regulator_control_regs;
    import regulator_pkg::*;

    logic        mclk;
    logic        resetn;
    reg_req_s    req;
    logic [7:0]  rdata;
    logic        rvalid;
    rail_pins_s  buck_pins;
    rail_pins_s  linreg_pins;
    logic        undervoltage_or_reset_load;
    logic        buck_enable;
    logic        linreg_enable;
    logic        buck_dis;
    logic        lin_dis;
    logic [5:0]  buck_code;
    logic [5:0]  lin_code;
    logic [11:0] buck_mv;
    logic [11:0] lin_mv;
    logic        forced_pwm;
    logic        overstep_reset;
    logic [5:0]  div_buck;
    logic [5:0]  div_lin;
    logic [7:0]  d;
    logic        v;
    logic [7:0]  b;
    logic [7:0]  l;
    int          err_count = 0;
    int          n_checks = 0;
    int          over_count = 0;
    logic [5:0]  corner [6] = '{6'h00, 6'h1f, 6'h20, 6'h3c, 6'h3d, 6'h3f};
    localparam logic [11:0] DIV_BUCK = 12'(BUCK_DEFAULT_BASE[5:0]);
    localparam logic [11:0] DIV_LIN  = 12'(LINREG_DEFAULT[5:0]);

    regulator_control_regs #(.VARIANT(VARIANT_MEASURE)) dut (
        .mclk                       (mclk),
        .resetn                     (resetn),
        .req                        (req),
        .rdata                      (rdata),
        .rvalid                     (rvalid),
        .buck_pins                  (buck_pins),
        .linreg_pins                (linreg_pins),
        .undervoltage_or_reset_load (undervoltage_or_reset_load),
        .buck_enable                (buck_enable),
        .linreg_enable              (linreg_enable),
        .buck_out_discharge         (buck_dis),
        .linreg_out_discharge       (lin_dis),
        .buck_applied_code          (buck_code),
        .linreg_applied_code        (lin_code),
        .buck_target_mv             (buck_mv),
        .linreg_target_mv           (lin_mv),
        .forced_pwm                 (forced_pwm),
        .overstep_reset             (overstep_reset)
    );

    // Divider variant on the same stimulus, codes must never apply
    regulator_control_regs #(.VARIANT(VARIANT_LARGE)) dut_div (
        .mclk                       (mclk),
        .resetn                     (resetn),
        .req                        (req),
        .rdata                      (),
        .rvalid                     (),
        .buck_pins                  (buck_pins),
        .linreg_pins                (linreg_pins),
        .undervoltage_or_reset_load (undervoltage_or_reset_load),
        .buck_enable                (),
        .linreg_enable              (),
        .buck_out_discharge         (),
        .linreg_out_discharge       (),
        .buck_applied_code          (div_buck),
        .linreg_applied_code        (div_lin),
        .buck_target_mv             (),
        .linreg_target_mv           (),
        .forced_pwm                 (),
        .overstep_reset             ()
    );

    regulator_host_model host (
        .mclk   (mclk),
        .req    (req),
        .rdata  (rdata),
        .rvalid (rvalid)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        if (overstep_reset === 1'b1)
            over_count <= over_count + 1;
    end

    function automatic logic [11:0] code_mv(input logic [5:0] c);
        if (c < 6'h20)
            return 12'h320 + 12'h019 * 12'(c);
        if (c < 6'h3d)
            return 12'h640 + 12'h032 * 12'(c - 6'h20);
        return 12'hc1c + 12'h064 * 12'(c - 6'h3d);
    endfunction

    task automatic check(input string name, input logic [11:0] seen,
                         input logic [11:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d, v);
        check("rvalid", 12'(v), 12'h001);
        check("rdata", 12'(d), 12'(exp));
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        #300000;
        err_count++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        undervoltage_or_reset_load = 1'b0;
        buck_pins = '{hold: 1'b0, pushbutton_n: 1'b1, in_range: 1'b1};
        linreg_pins = '{hold: 1'b0, pushbutton_n: 1'b1, in_range: 1'b1};
        void'($urandom(94620));
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        // Defaults and read-only bits
        rdchk(BUCK_SETTING_ADDR, BUCK_DEFAULT_MEASURE);
        rdchk(LINREG_SETTING_ADDR, LINREG_DEFAULT);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h60);
        check("lin_dis", 12'(lin_dis), 12'h001);
        // Code table corners, then random settings
        for (int i = 0; i < 30; i++) begin
            b = 8'($urandom);
            l = 8'($urandom);
            if (i < 6)
                b[5:0] = corner[i];
            host.wr(BUCK_SETTING_ADDR, b);
            host.wr(LINREG_SETTING_ADDR, l);
            idle(3);
            rdchk(BUCK_SETTING_ADDR, b);
            rdchk(LINREG_SETTING_ADDR, l);
            check("buck_code", 12'(buck_code), 12'(b[5:0]));
            check("buck_mv", buck_mv, code_mv(b[5:0]));
            check("lin_mv", lin_mv, code_mv(l[5:0]));
            check("buck_dis", 12'(buck_dis), 12'(b[6]));
            check("lin_dis", 12'(lin_dis), 12'(l[6]));
            check("lin_code", 12'(lin_code), 12'(l[5:0]));
            check("div_buck", 12'(div_buck), DIV_BUCK);
            check("div_lin", 12'(div_lin), DIV_LIN);
        end
        // Mode bits and an unmapped place
        host.wr(MODE_AND_POWER_GOOD_ADDR, 8'hff);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'he0);
        check("forced_pwm", 12'(forced_pwm), 12'h001);
        host.wr(MODE_AND_POWER_GOOD_ADDR, 8'h1f);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h60);
        check("forced_pwm", 12'(forced_pwm), 12'h000);
        host.wr(8'h0a, 8'h77);
        rdchk(8'h0a, 8'h00);
        // Rails on by hold pins, power-bad follows in_range
        host.wr(BUCK_SETTING_ADDR, 8'h40);
        host.wr(LINREG_SETTING_ADDR, 8'h40);
        buck_pins.hold = 1'b1;
        linreg_pins.hold = 1'b1;
        idle(8);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h00);
        check("lin_dis", 12'(lin_dis), 12'h000);
        check("buck_dis", 12'(buck_dis), 12'h000);
        buck_pins.in_range = 1'b0;
        idle(8);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h40);
        // Small raise within limit, then a large one
        host.wr(BUCK_SETTING_ADDR, 8'h01);
        idle(3);
        check("overstep", 12'(over_count), 12'h000);
        host.wr(BUCK_SETTING_ADDR, 8'h10);
        idle(3);
        check("overstep", 12'(over_count), 12'h001);
        // Hold pins released with and without keep bits
        host.wr(BUCK_SETTING_ADDR, 8'h90);
        buck_pins.hold = 1'b0;
        linreg_pins.hold = 1'b0;
        idle(8);
        check("buck_en", 12'(buck_enable), 12'h001);
        check("lin_en", 12'(linreg_enable), 12'h000);
        check("lin_dis", 12'(lin_dis), 12'h001);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h60);
        host.wr(BUCK_SETTING_ADDR, 8'h50);
        idle(8);
        check("buck_en", 12'(buck_enable), 12'h000);
        check("buck_dis", 12'(buck_dis), 12'h001);
        // Push-button press and release
        buck_pins.pushbutton_n = 1'b0;
        idle(8);
        check("buck_en", 12'(buck_enable), 12'h001);
        check("lin_en", 12'(linreg_enable), 12'h001);
        buck_pins.pushbutton_n = 1'b1;
        idle(8);
        check("buck_en", 12'(buck_enable), 12'h000);
        check("lin_en", 12'(linreg_enable), 12'h000);
        // Undervoltage reload, then a reset in mid-run
        host.wr(MODE_AND_POWER_GOOD_ADDR, 8'h80);
        host.wr(LINREG_SETTING_ADDR, 8'h0c);
        undervoltage_or_reset_load = 1'b1;
        idle(8);
        undervoltage_or_reset_load = 1'b0;
        idle(8);
        rdchk(BUCK_SETTING_ADDR, BUCK_DEFAULT_MEASURE);
        rdchk(LINREG_SETTING_ADDR, LINREG_DEFAULT);
        rdchk(MODE_AND_POWER_GOOD_ADDR, 8'h60);
        host.wr(BUCK_SETTING_ADDR, 8'h11);
        resetn = 1'b0;
        idle(4);
        resetn = 1'b1;
        rdchk(BUCK_SETTING_ADDR, BUCK_DEFAULT_MEASURE);
        wrap_up();
    end
endmodule
